/* File: rtl/swc_counter.sv */
// Free counter with clear, enable and wrap pulse
module swc_counter #(
  parameter int W = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic clr_i,
  input wire logic en_i,
  output logic [W-1:0] cnt_o,
  output logic wrap_o
);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_o <= '0;
    end else if (clr_i) begin
      cnt_o <= '0;
    end else if (en_i) begin
      cnt_o <= cnt_o + 1'b1;
    end
  end

  assign wrap_o = en_i & ~clr_i & (&cnt_o);

endmodule : swc_counter

/* File: rtl/swc_pkg.sv */
// Types shared by the sleep and wake controller
package swc_pkg;

  typedef enum logic [1:0] {
    SWC_OSC_LOW_FREQ_XTAL = 2'h0,
    SWC_OSC_RC = 2'h1,
    SWC_OSC_XTAL = 2'h2,
    SWC_OSC_EXT_CLOCK = 2'h3
  } swc_osc_mode_t;

  typedef enum logic [1:0] {
    SWC_ST_RUN,
    SWC_ST_SLEEP,
    SWC_ST_SETTLE
  } swc_state_t;

  typedef enum logic [1:0] {
    SWC_WK_NONE,
    SWC_WK_IRQ,
    SWC_WK_WDT,
    SWC_WK_MASTER_RESET_PIN
  } swc_wake_t;

  // One bit per interrupt source
  typedef struct packed {
    logic rx_full;
    logic tx_empty;
    logic port_chg;
    logic cap2;
    logic cap1;
    logic int_pin;
    logic timer_pin;
  } swc_irq_t;

endpackage : swc_pkg

/* File: rtl/swc_regs.svh */
// Register map, field positions, reset values and timing counts
`ifndef SWC_REGS_SVH
`define SWC_REGS_SVH

// Word indices; byte address is four times the index
`define SWC_IDX_CPU_STATUS 6'h06
`define SWC_IDX_WAKE_CTRL 6'h07
`define SWC_IDX_WAKE_INFO 6'h08

// cpu_status fields
`define SWC_BIT_STACK_AVAIL 5
`define SWC_BIT_GID 4
`define SWC_BIT_WDT_EXPIRY 3
`define SWC_BIT_SLEEP_ENTERED 2
`define SWC_CPU_STATUS_RST 8'h3C

// wake_ctrl fields
`define SWC_BIT_OSC_MODE_LO 0
`define SWC_BIT_WDT_ENABLE 2
`define SWC_BIT_TIMER_EXT 3
`define SWC_BIT_EDGE_SEL 4
`define SWC_BIT_SYNC_RX_EN 5
`define SWC_WAKE_CTRL_RST 6'h06

// Oscillator settle time in oscillator periods
`define SWC_OST_PERIODS 1024
`define SWC_OST_WIDTH 10

`endif

/* File: rtl/swc_top.sv */
// Sleep and wake controller with cpu_status register
//
// Implementation choice: the Wishbone interface to the registers.
`include "swc_regs.svh"

module swc_top
  import swc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sleep_exec_i,
  input wire logic clear_watchdog_i,
  input wire logic watchdog_tick_i,
  input wire logic master_reset_pin_n_i,
  input wire logic stack_full_i,
  input wire logic timer_clock_pin_i,
  input wire logic capture1_pin_i,
  input wire logic [7:0] port_b_i,
  input wire logic ser_clk_i,
  input wire logic ser_data_i,
  input wire logic tx_busy_i,
  input wire logic tx_done_i,
  input wire swc_irq_t irq_event_i,
  input wire swc_irq_t irq_enable_i,
  input wire swc_irq_t irq_clear_i,
  output swc_irq_t irq_pending_o,
  output logic irq_req_o,
  output logic cpu_hold_reset_o,
  output logic wake_resume_o,
  output logic wake_vector_o,
  output logic watchdog_reset_o,
  output logic core_clk_en_o,
  output logic osc_en_o,
  output logic osc_in_oe_o,
  output logic osc_out_o,
  output logic osc_out_oe_o,
  output logic io_hold_o,
  output logic prog_mem_power_o,
  output logic watchdog_fuse_power_o,
  output logic timer_tick_o,
  output logic capture_latch_o,
  output logic [7:0] rx_word_o
);

  // Reset release through two flip-flops
  logic rst_s1_q;
  logic rst_n;
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  swc_state_t state_q, state_d;
  swc_wake_t cause_q, cause_d;
  logic gid_q, to_q, pd_q;
  logic [5:0] ctrl_q;
  swc_irq_t pend_q, mask_q;
  logic gid_at_wake_q;
  logic tx_at_entry_q;
  logic cap_defer_q;

  // Wishbone slave, one wait state
  logic ack_q;
  logic [31:0] rdat_q;
  wire wb_req = wb_cyc_i & wb_stb_i;
  wire [5:0] wb_idx = wb_adr_i[7:2];
  wire wb_wr = wb_req & wb_we_i & ack_q & wb_sel_i[0];
  wire hit_status = wb_idx == `SWC_IDX_CPU_STATUS;
  wire hit_ctrl = wb_idx == `SWC_IDX_WAKE_CTRL;
  wire hit_info = wb_idx == `SWC_IDX_WAKE_INFO;
  wire wr_status = wb_wr & hit_status;
  wire wr_ctrl = wb_wr & hit_ctrl;

  wire asleep = state_q == SWC_ST_SLEEP;
  wire running = state_q == SWC_ST_RUN;
  wire [1:0] state_code = state_q;
  wire swc_osc_mode_t osc_mode = swc_osc_mode_t'(ctrl_q[1:0]);
  wire xtal = (osc_mode == SWC_OSC_XTAL) |
    (osc_mode == SWC_OSC_LOW_FREQ_XTAL);
  wire wdt_on = ctrl_q[`SWC_BIT_WDT_ENABLE];
  wire timer_ext = ctrl_q[`SWC_BIT_TIMER_EXT];
  wire edge_sel = ctrl_q[`SWC_BIT_EDGE_SEL];
  wire rx_en = ctrl_q[`SWC_BIT_SYNC_RX_EN];

  wire stack_avail = ~stack_full_i;
  wire [7:0] status_rd = {2'h0, stack_avail, gid_q, to_q, pd_q,
    2'h0};
  wire [7:0] ctrl_rd = {state_code, ctrl_q};
  wire [7:0] info_rd = {1'b0, pend_q};
  wire [7:0] rd_mux = hit_status ? status_rd :
    hit_ctrl ? ctrl_rd :
    hit_info ? info_rd : 8'h00;

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0;
    end else begin
      ack_q <= wb_req & ~ack_q;
      if (wb_req & ~ack_q) begin
        rdat_q <= {24'h0, rd_mux};
      end
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // Edge and change detection on synchronous pins
  logic tpin_q, cap1_q, sclk_q;
  logic [7:0] portb_q;
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tpin_q <= 1'b0;
      cap1_q <= 1'b0;
      sclk_q <= 1'b0;
      portb_q <= 8'h00;
    end else begin
      tpin_q <= timer_clock_pin_i;
      cap1_q <= capture1_pin_i;
      sclk_q <= ser_clk_i;
      portb_q <= port_b_i;
    end
  end
  wire tpin_rise = timer_clock_pin_i & ~tpin_q;
  wire tpin_fall = ~timer_clock_pin_i & tpin_q;
  wire tpin_edge = edge_sel ? tpin_rise : tpin_fall;
  wire cap1_rise = capture1_pin_i & ~cap1_q;
  wire sclk_rise = ser_clk_i & ~sclk_q;
  wire port_chg = port_b_i != portb_q;

  // Timer prescaler counts pin edges in any state
  logic tpre_wrap;
  swc_counter #(.W(8)) u_timer_pre (
    .clk_i(sys_clk_i),
    .rst_n_i(rst_n),
    .clr_i(1'b0),
    .en_i(timer_ext & tpin_edge),
    .cnt_o(),
    .wrap_o(tpre_wrap)
  );

  // Capture input prescaler, by four
  logic cpre_wrap;
  swc_counter #(.W(2)) u_cap_pre (
    .clk_i(sys_clk_i),
    .rst_n_i(rst_n),
    .clr_i(1'b0),
    .en_i(cap1_rise),
    .cnt_o(),
    .wrap_o(cpre_wrap)
  );

  // Sleep entry; pending enabled interrupt turns it into a no-op
  wire irq_seen = |(pend_q & irq_enable_i);
  wire sleep_enter = running & sleep_exec_i & ~irq_seen;

  // Watchdog with its prescaler
  logic wdt_wrap;
  swc_counter #(.W(16)) u_wdt (
    .clk_i(sys_clk_i),
    .rst_n_i(rst_n),
    .clr_i(sleep_enter | clear_watchdog_i),
    .en_i(wdt_on & watchdog_tick_i),
    .cnt_o(),
    .wrap_o(wdt_wrap)
  );
  wire wdt_expire = wdt_wrap & (running | asleep);

  // Synchronous slave receiver shifts on external clock
  logic [7:0] rx_sr_q;
  logic [2:0] rx_cnt_q;
  wire rx_done = sclk_rise & (&rx_cnt_q);
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_sr_q <= 8'h00;
      rx_cnt_q <= 3'h0;
    end else if (rx_en & sclk_rise) begin
      rx_sr_q <= {rx_sr_q[6:0], ser_data_i};
      rx_cnt_q <= rx_cnt_q + 3'h1;
    end
  end

  // Interrupt events; set wins over clear
  wire ev_tx_empty = tx_done_i & (~asleep | tx_at_entry_q);
  wire ev_rx_full = rx_en & rx_done;
  wire swc_irq_t ev = {
    ev_rx_full, ev_tx_empty, port_chg,
    irq_event_i.cap2,
    cpre_wrap,
    irq_event_i.int_pin, irq_event_i.timer_pin
  };
  wire swc_irq_t pend_d = (pend_q & ~irq_clear_i) | ev;

  // Wake sources while asleep
  wire irq_wake = |(pend_q & mask_q);
  wire master_reset_pin_low = ~master_reset_pin_n_i;
  wire wake_ev = asleep & (irq_wake | wdt_expire | master_reset_pin_low);

  // Oscillator settle timer
  logic ost_wrap;
  swc_counter #(.W(`SWC_OST_WIDTH)) u_ost (
    .clk_i(sys_clk_i),
    .rst_n_i(rst_n),
    .clr_i(state_q != SWC_ST_SETTLE),
    .en_i(master_reset_pin_n_i),
    .cnt_o(),
    .wrap_o(ost_wrap)
  );

  // Wake sequencing
  always_comb begin
    state_d = state_q;
    cause_d = cause_q;
    case (state_q)
      SWC_ST_RUN: begin
        if (sleep_enter) begin
          state_d = SWC_ST_SLEEP;
          cause_d = SWC_WK_NONE;
        end
      end
      SWC_ST_SLEEP: begin
        if (wake_ev) begin
          if (master_reset_pin_low) begin
            cause_d = SWC_WK_MASTER_RESET_PIN;
          end else if (wdt_expire) begin
            cause_d = SWC_WK_WDT;
          end else begin
            cause_d = SWC_WK_IRQ;
          end
          state_d = xtal ? SWC_ST_SETTLE : SWC_ST_RUN;
        end
      end
      SWC_ST_SETTLE: begin
        if (ost_wrap) begin
          state_d = SWC_ST_RUN;
        end
      end
      default: begin
        state_d = SWC_ST_RUN;
      end
    endcase
  end

  wire leave = (asleep & wake_ev & ~xtal) |
    ((state_q == SWC_ST_SETTLE) & ost_wrap);
  wire swc_wake_t leave_cause = asleep ? cause_d : cause_q;
  wire irq_leave = leave & (leave_cause == SWC_WK_IRQ);

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= SWC_ST_RUN;
      cause_q <= SWC_WK_NONE;
    end else begin
      state_q <= state_d;
      cause_q <= cause_d;
    end
  end

  // Captured at sleep entry or at the wake event
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= '0;
      tx_at_entry_q <= 1'b0;
      gid_at_wake_q <= 1'b1;
    end else begin
      if (sleep_enter) begin
        mask_q <= irq_enable_i;
        tx_at_entry_q <= tx_busy_i;
      end
      if (wake_ev) begin
        gid_at_wake_q <= gid_q;
      end
    end
  end
  wire gid_now = asleep ? gid_q : gid_at_wake_q;

  // Status and control registers
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      gid_q <= 1'(`SWC_CPU_STATUS_RST >> `SWC_BIT_GID);
      to_q <= 1'(`SWC_CPU_STATUS_RST >> `SWC_BIT_WDT_EXPIRY);
      pd_q <= 1'(`SWC_CPU_STATUS_RST >> `SWC_BIT_SLEEP_ENTERED);
      ctrl_q <= `SWC_WAKE_CTRL_RST;
      pend_q <= '0;
    end else begin
      pend_q <= pend_d;
      if (wr_ctrl) begin
        ctrl_q <= wb_dat_i[5:0];
      end
      if (wr_status) begin
        gid_q <= wb_dat_i[`SWC_BIT_GID];
      end
      if (wdt_expire) begin
        to_q <= 1'b0;
      end else if (sleep_enter | clear_watchdog_i) begin
        to_q <= 1'b1;
      end else if (wr_status) begin
        to_q <= wb_dat_i[`SWC_BIT_WDT_EXPIRY];
      end
      if (sleep_enter) begin
        pd_q <= 1'b0;
      end else if (wr_status) begin
        pd_q <= wb_dat_i[`SWC_BIT_SLEEP_ENTERED];
      end
    end
  end

  // Capture latch deferred until execution resumes
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cap_defer_q <= 1'b0;
    end else if (leave) begin
      cap_defer_q <= 1'b0;
    end else if (cpre_wrap & ~running) begin
      cap_defer_q <= 1'b1;
    end
  end

  // Wake action and interrupt request pulses
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wake_resume_o <= 1'b0;
      wake_vector_o <= 1'b0;
      watchdog_reset_o <= 1'b0;
      irq_req_o <= 1'b0;
      irq_pending_o <= '0;
      timer_tick_o <= 1'b0;
      capture_latch_o <= 1'b0;
    end else begin
      wake_resume_o <= irq_leave & gid_now;
      wake_vector_o <= irq_leave & ~gid_now;
      watchdog_reset_o <= (running & wdt_expire) |
        (leave & (leave_cause == SWC_WK_WDT));
      irq_req_o <= running & ~gid_q & irq_seen;
      irq_pending_o <= pend_q;
      timer_tick_o <= running & tpre_wrap;
      capture_latch_o <= (running & cpre_wrap) |
        (leave & (cap_defer_q | cpre_wrap));
    end
  end

  // Reset hold: reset pin low or settle timer running
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cpu_hold_reset_o <= 1'b1;
    end else begin
      cpu_hold_reset_o <= master_reset_pin_low |
        (state_d == SWC_ST_SETTLE);
    end
  end

  // Clock output divider, quarter of oscillator rate
  logic [1:0] div_q;
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 2'h0;
    end else begin
      div_q <= div_q + 2'h1;
    end
  end

  // Oscillator, clocks, pins and power
  wire sleep_d = state_d == SWC_ST_SLEEP;
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      core_clk_en_o <= 1'b0;
      osc_en_o <= 1'b1;
      osc_in_oe_o <= 1'b0;
      osc_out_o <= 1'b0;
      osc_out_oe_o <= 1'b0;
      io_hold_o <= 1'b0;
      prog_mem_power_o <= 1'b1;
      watchdog_fuse_power_o <= 1'b1;
    end else begin
      core_clk_en_o <= state_d == SWC_ST_RUN;
      osc_en_o <= ~sleep_d;
      osc_in_oe_o <= 1'b0;
      osc_out_o <= ~sleep_d & ~xtal & div_q[1];
      osc_out_oe_o <= ~xtal;
      io_hold_o <= sleep_d;
      prog_mem_power_o <= ~sleep_d;
      watchdog_fuse_power_o <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_word_o <= 8'h00;
    end else if (rx_en & rx_done) begin
      rx_word_o <= {rx_sr_q[6:0], ser_data_i};
    end
  end

endmodule : swc_top

/* File: test/swc_cpu_model.sv */
// Core and interrupt source model: requests are registered and appear one cycle later
module swc_cpu_model
  import swc_pkg::*;
(
  input wire logic clk_i,
  input wire logic sleep_req_i,
  input wire swc_irq_t fire_i,
  output logic sleep_exec_o,
  output swc_irq_t irq_event_o
);
  timeunit 1ns;
  timeprecision 100ps;
  always_ff @(posedge clk_i) begin
    sleep_exec_o <= sleep_req_i;
    irq_event_o <= fire_i;
  end
endmodule : swc_cpu_model

/* File: test/swc_top_asserts.sv */
// Port-level assertions for the sleep and wake controller
module swc_top_asserts
  import swc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic sleep_exec_i,
  input wire logic wb_ack_o,
  input wire logic irq_req_o,
  input wire logic core_clk_en_o,
  input wire logic osc_en_o,
  input wire logic osc_in_oe_o,
  input wire logic osc_out_o,
  input wire logic io_hold_o,
  input wire logic prog_mem_power_o,
  input wire logic watchdog_fuse_power_o,
  input wire logic timer_tick_o,
  input wire logic wake_resume_o,
  input wire logic wake_vector_o,
  input wire swc_irq_t irq_enable_i,
  input wire swc_irq_t irq_pending_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_sleep_entry: assert property (
    sleep_exec_i && core_clk_en_o |=>
      io_hold_o || (|(irq_pending_o & $past(irq_enable_i))))
    else $error("sleep not entered");
  a_clocks_gated: assert property (
    io_hold_o |-> !core_clk_en_o && !osc_en_o)
    else $error("clocks running while asleep");
  a_osc_in_hiz: assert property (!osc_in_oe_o)
    else $error("oscillator input driven");
  a_osc_out_low: assert property (io_hold_o |-> !osc_out_o)
    else $error("oscillator output high in sleep");
  a_mem_off: assert property (
    io_hold_o |-> !prog_mem_power_o && watchdog_fuse_power_o)
    else $error("memory power wrong in sleep");
  a_timer_frozen: assert property (io_hold_o |-> !timer_tick_o)
    else $error("timer advanced in sleep");
  a_wake_once: assert property (
    (wake_vector_o || wake_resume_o) |->
      core_clk_en_o && !(wake_vector_o && wake_resume_o))
    else $error("bad wake pulse");

  c_sleep: cover property ($rose(io_hold_o));
  c_vector: cover property (wake_vector_o);
  c_resume: cover property (wake_resume_o);
endmodule : swc_top_asserts

bind swc_top swc_top_asserts u_asserts (
  .sys_clk_i, .reset_n_i, .sleep_exec_i, .wb_ack_o, .irq_req_o,
  .core_clk_en_o, .osc_en_o, .osc_in_oe_o, .osc_out_o, .io_hold_o,
  .prog_mem_power_o, .watchdog_fuse_power_o, .timer_tick_o,
  .wake_resume_o, .wake_vector_o, .irq_enable_i, .irq_pending_o
);

/* File: test/tb_sleep_wake_controller.sv */
// Self-checking bench for the sleep and wake controller
module tb_sleep_wake_controller
  import swc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk_i = 1'b0, reset_n_i = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [7:0] wb_adr_i = 8'h00, port_b_i = 8'h00, rx_word_o;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic sleep_exec_i, sleep_req = 1'b0, clear_watchdog_i = 1'b0;
  logic watchdog_tick_i = 1'b0, master_reset_pin_n_i = 1'b1;
  logic stack_full_i = 1'b0, timer_clock_pin_i = 1'b0;
  logic capture1_pin_i = 1'b0, ser_clk_i = 1'b0, ser_data_i = 1'b0;
  logic tx_busy_i = 1'b0, tx_done_i = 1'b0;
  swc_irq_t irq_event_i, irq_pending_o, fire = '0;
  swc_irq_t irq_enable_i = '0, irq_clear_i = '0;
  logic irq_req_o, cpu_hold_reset_o, wake_resume_o, wake_vector_o;
  logic watchdog_reset_o, core_clk_en_o, osc_en_o, osc_in_oe_o;
  logic osc_out_o, osc_out_oe_o, io_hold_o, prog_mem_power_o;
  logic watchdog_fuse_power_o, timer_tick_o, capture_latch_o;
  int failures = 0, tests_run = 0, cycles = 0;

  swc_top dut (
    .sys_clk_i, .reset_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .sleep_exec_i,
    .clear_watchdog_i, .watchdog_tick_i, .master_reset_pin_n_i,
    .stack_full_i, .timer_clock_pin_i, .capture1_pin_i, .port_b_i,
    .ser_clk_i, .ser_data_i, .tx_busy_i,
    .tx_done_i, .irq_event_i, .irq_enable_i, .irq_clear_i,
    .irq_pending_o, .irq_req_o, .cpu_hold_reset_o, .wake_resume_o,
    .wake_vector_o, .watchdog_reset_o, .core_clk_en_o, .osc_en_o,
    .osc_in_oe_o, .osc_out_o, .osc_out_oe_o, .io_hold_o,
    .prog_mem_power_o, .watchdog_fuse_power_o, .timer_tick_o,
    .capture_latch_o, .rx_word_o
  );
  swc_cpu_model cpu (.clk_i(sys_clk_i), .sleep_req_i(sleep_req),
    .fire_i(fire), .sleep_exec_o(sleep_exec_i), .irq_event_o(irq_event_i));

  initial begin
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  task automatic final_report();
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 90000) begin
      failures++;
      final_report();
    end
  end

  task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic bus(logic w, logic [7:0] a, d, output logic [7:0] q);
    @(posedge sys_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h000000, d};
    do @(posedge sys_clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : bus

  task automatic wr(logic [7:0] a, d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd_chk(string what, logic [7:0] a, exp);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    cmp(what, exp, q);
  endtask : rd_chk

  task automatic go_sleep(logic exp);
    @(posedge sys_clk_i);
    sleep_req <= 1'b1;
    @(posedge sys_clk_i);
    sleep_req <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    cmp("io_hold", exp, io_hold_o);
    cmp("clk_en", !exp, core_clk_en_o);
  endtask : go_sleep

  // Waits for the first wake pulse, counting held-in-reset cycles
  task automatic wake_chk(logic [2:0] exp, output int n);
    logic [2:0] got;
    n = 0;
    got = 3'h0;
    for (int i = 0; i < 70000 && got == 3'h0; i++) begin
      @(posedge sys_clk_i);
      got = {watchdog_reset_o, wake_vector_o, wake_resume_o};
      n += cpu_hold_reset_o;
    end
    cmp("wake", exp, got);
  endtask : wake_chk

  task automatic t_regs();
    rd_chk("reset", 8'h18, 8'h3C);
    stack_full_i <= 1'b1;
    rd_chk("stack", 8'h18, 8'h1C);
    stack_full_i <= 1'b0;
    wr(8'h18, 8'hFF);
    rd_chk("ones", 8'h18, 8'h3C);
    wr(8'h18, 8'h00);
    rd_chk("zeros", 8'h18, 8'h20);
    rd_chk("unmapped", 8'h40, 8'h00);
  endtask : t_regs

  task automatic t_irq(logic gid, swc_irq_t src, logic pb);
    int n;
    wr(8'h1C, 8'h03);
    wr(8'h18, {3'h0, gid, 4'hC});
    irq_enable_i <= src;
    go_sleep(1'b1);
    cmp("osc_out", 2'h2, {osc_out_oe_o, osc_out_o});
    fire <= swc_irq_t'(7'h08);
    @(posedge sys_clk_i);
    fire <= '0;
    repeat (8) @(posedge sys_clk_i);
    cmp("masked", 1, io_hold_o);
    if (pb) port_b_i <= ~port_b_i;
    else fire <= src;
    @(posedge sys_clk_i);
    fire <= '0;
    wake_chk({1'b0, !gid, gid}, n);
    rd_chk("status", 8'h18, {3'h1, gid, 4'h8});
    cmp("irq_req", !gid, irq_req_o);
    cmp("pending", src | swc_irq_t'(7'h08), irq_pending_o);
    irq_clear_i <= '1;
    @(posedge sys_clk_i);
    irq_clear_i <= '0;
  endtask : t_irq

  task automatic t_wdt();
    int n;
    wr(8'h1C, 8'h06);
    wr(8'h18, 8'h1C);
    irq_enable_i <= '0;
    go_sleep(1'b1);
    cmp("osc_out_oe", 0, osc_out_oe_o);
    watchdog_tick_i <= 1'b1;
    wake_chk(3'h4, n);
    watchdog_tick_i <= 1'b0;
    cmp("settle", 1024, n);
    rd_chk("status", 8'h18, 8'h30);
  endtask : t_wdt

  // Pins active in sleep, receive wake, no-op sleep, transmit wake
  task automatic t_ser();
    int n;
    int ticks;
    logic [7:0] w;
    w = 8'hA5;
    ticks = 0;
    wr(8'h1C, 8'h2B);
    wr(8'h18, 8'h1C);
    irq_enable_i <= swc_irq_t'(7'h40);
    go_sleep(1'b1);
    for (int i = 0; i < 600; i++) begin
      timer_clock_pin_i <= ~timer_clock_pin_i;
      capture1_pin_i <= (i < 8) & ~capture1_pin_i;
      @(posedge sys_clk_i);
      ticks += timer_tick_o;
    end
    cmp("timer_tick", 0, ticks);
    cmp("cap_asleep", 1, io_hold_o);
    for (int i = 7; i >= 0; i--) begin
      ser_data_i <= w[i];
      ser_clk_i <= 1'b0;
      @(posedge sys_clk_i);
      ser_clk_i <= 1'b1;
      @(posedge sys_clk_i);
    end
    ser_clk_i <= 1'b0;
    wake_chk(3'h1, n);
    cmp("rx_word", 8'hA5, rx_word_o);
    cmp("cap_latch", 1, capture_latch_o);
    rd_chk("status", 8'h18, 8'h38);
    wr(8'h18, 8'h1C);
    go_sleep(1'b0);
    rd_chk("pd_kept", 8'h18, 8'h3C);
    irq_clear_i <= '1;
    tx_busy_i <= 1'b1;
    irq_enable_i <= swc_irq_t'(7'h20);
    @(posedge sys_clk_i);
    irq_clear_i <= '0;
    go_sleep(1'b1);
    tx_busy_i <= 1'b0;
    tx_done_i <= 1'b1;
    @(posedge sys_clk_i);
    tx_done_i <= 1'b0;
    wake_chk(3'h1, n);
    irq_clear_i <= '1;
    @(posedge sys_clk_i);
    irq_clear_i <= '0;
  endtask : t_ser

  initial begin
    repeat (3) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    t_regs();
    t_irq(1'b1, swc_irq_t'(7'h02), 1'b0);
    t_irq(1'b0, swc_irq_t'(7'h01), 1'b0);
    t_irq(1'b0, swc_irq_t'(7'h10), 1'b1);
    t_ser();
    t_wdt();
    final_report();
  end
endmodule : tb_sleep_wake_controller
